// file: hw/dlu_ctrl.sv
/*
 * Update-path control for an eight-channel converter: reset loading, output clear,
 * load-latch strobe, update mode selection and per-channel latch reload.
 * Assumes all pins are synchronous to ref_clk_i and that the serial port decodes
 * frames elsewhere and presents completed writes on the write ports.
 */
`timescale 1ns/1ps

module dlu_ctrl #(
    parameter int NUM_CH = dlu_pkg::NUM_CH,
    parameter int CODE_W = dlu_pkg::CODE_W
) (
    // Clock, reset and clock enable.
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       clk_en_i,

    // Output control strobes and strap levels.
    input  wire logic                       output_clear_n_i,
    input  wire logic                       load_latch_n_i,
    input  wire logic                       hw_reset_n_i,
    input  wire dlu_pkg::dlu_strap_t        strap_i,

    // Serial pins from the host.
    input  wire logic                       cs_n_i,
    input  wire logic                       sdi_i,
    input  wire logic                       sdo_data_i,

    // Correction engine and completed channel writes.
    input  wire logic                       correction_enable_i,
    input  wire logic                       correction_busy_i,
    input  wire dlu_pkg::dlu_wr_t           host_wr_i,
    input  wire dlu_pkg::dlu_wr_t           engine_wr_i,

    // Software load and calibration writes.
    input  wire logic                       latch_load_cmd_wr_i,
    input  wire logic                       gain_wr_i,
    input  wire logic                       zero_wr_i,
    input  wire logic [CODE_W-1:0]          cal_data_i,

    // Serial pins towards the shift register.
    output logic                            cs_n_o,
    output logic                            sdi_o,
    output logic                            sdo_o,
    output logic                            sdo_oe_n_o,
    output logic                            serial_enable_o,

    // Update mode and load status.
    output logic                            async_mode_o,
    output logic                            latch_load_cmd_o,

    // Channel outputs and registers.
    output logic [NUM_CH-1:0]               out_ground_o,
    output logic [NUM_CH-1:0]               out_buf_hiz_o,
    output logic [NUM_CH*CODE_W-1:0]        out_code_o,
    output logic [NUM_CH*CODE_W-1:0]        chan_data_o,
    output logic [CODE_W-1:0]               input_data_o,
    output logic [CODE_W-1:0]               offset_o,
    output logic                            offset_on_o,
    output logic [CODE_W-1:0]               gain_o,
    output logic [CODE_W-1:0]               zero_o
);

    dlu_pkg::dlu_state_t          state;
    dlu_pkg::dlu_state_t          next_state;
    dlu_pkg::dlu_mode_t           mode;
    logic [CODE_W-1:0]            chan_data [NUM_CH];
    logic [CODE_W-1:0]            latch     [NUM_CH];
    logic [NUM_CH-1:0]            written;

    // Strobe history and load bookkeeping.
    logic                         cleared;
    logic                         load_latch_n_q;
    logic                         cs_q;
    logic                         load_pending;
    logic                         load_all;

    // Decoded conditions.
    logic                         in_reset;
    logic                         load_latch_n_fall;
    logic                         cs_rise;
    logic                         sync_load;
    logic [CODE_W-1:0]            reset_code;
    logic [NUM_CH-1:0]            load_ch;

    // Reset code depends only on whether the two select pins agree; the supply
    // choice only changes the offset.
    assign reset_code = (strap_i.reset_level_select == strap_i.code_format_select) ?
                        dlu_pkg::CODE_ZERO : dlu_pkg::CODE_MID;

    // The reset pin acts at once, without waiting for the state to follow.
    assign in_reset  = (state != dlu_pkg::DLU_ST_RUN) || !hw_reset_n_i;
    assign load_latch_n_fall = load_latch_n_q && !load_latch_n_i;
    assign cs_rise   = !cs_q && cs_n_i && serial_enable_o;

    // Power-up, hardware reset and run sequencing.
    always_comb begin
        next_state = state;
        case (state)
            dlu_pkg::DLU_ST_POWERUP: begin
                next_state = dlu_pkg::DLU_ST_RESET;
            end
            dlu_pkg::DLU_ST_RESET: begin
                if (hw_reset_n_i) begin
                    next_state = dlu_pkg::DLU_ST_RUN;
                end
            end
            default: begin
                if (!hw_reset_n_i) begin
                    next_state = dlu_pkg::DLU_ST_RESET;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state <= dlu_pkg::DLU_ST_POWERUP;
        end else if (clk_en_i) begin
            state <= next_state;
        end
    end

    // The strobe level is strapped once, at the first enabled edge after reset;
    // later strobe activity must never flip the update mode.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mode <= dlu_pkg::DLU_MODE_SYNC;
        end else if (clk_en_i && state == dlu_pkg::DLU_ST_POWERUP) begin
            mode <= load_latch_n_i ? dlu_pkg::DLU_MODE_SYNC
                                   : dlu_pkg::DLU_MODE_ASYNC;
        end
    end

    // Edge history of the strobes; chip select is blinded during reset.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            load_latch_n_q <= 1'b1;
            cs_q   <= 1'b1;
        end else if (clk_en_i) begin
            load_latch_n_q <= load_latch_n_i;
            cs_q   <= in_reset ? 1'b1 : cs_n_i;
        end
    end

    // Serial pass-through to the shift port, gated off during reset.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cs_n_o          <= 1'b1;
            sdi_o           <= 1'b0;
            sdo_o           <= 1'b0;
            sdo_oe_n_o      <= 1'b1;
        end else if (clk_en_i) begin
            cs_n_o          <= in_reset ? 1'b1 : cs_n_i;
            sdi_o           <= in_reset ? 1'b0 : sdi_i;
            sdo_o           <= in_reset ? 1'b0 : sdo_data_i;
            sdo_oe_n_o      <= in_reset || cs_n_i;
        end
    end

    // The port reports itself live one edge after the reset state is left.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            serial_enable_o <= 1'b0;
        end else if (clk_en_i) begin
            serial_enable_o <= !in_reset;
        end
    end

    // A software load is one event; it waits for the engine and then self-clears.
    // The strobe that releases a clear is itself a load, so the pin is tested here.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            load_pending <= 1'b0;
        end else if (clk_en_i) begin
            if (in_reset || mode == dlu_pkg::DLU_MODE_ASYNC) begin
                load_pending <= 1'b0;
            end else if ((latch_load_cmd_wr_i || load_latch_n_fall) && output_clear_n_i) begin
                load_pending <= 1'b1;
            end else if (!(correction_enable_i && correction_busy_i)) begin
                load_pending <= 1'b0;
            end
        end
    end

    assign latch_load_cmd_o = load_pending;
    assign sync_load = load_pending && !(correction_enable_i && correction_busy_i)
                       && mode == dlu_pkg::DLU_MODE_SYNC;

    // A software load reloads every channel, so it is remembered apart from the strobe.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            load_all <= 1'b0;
        end else if (clk_en_i) begin
            if (in_reset || mode == dlu_pkg::DLU_MODE_ASYNC) begin
                load_all <= 1'b0;
            end else if (latch_load_cmd_wr_i && output_clear_n_i) begin
                load_all <= 1'b1;
            end else if (sync_load) begin
                load_all <= 1'b0;
            end
        end
    end

    // Clear holds until a load strobe after release unless the strobe is held low.
    // A strobe held low therefore releases the outputs at once.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cleared <= 1'b0;
        end else if (clk_en_i) begin
            if (!output_clear_n_i) begin
                cleared <= 1'b1;
            end else if (!load_latch_n_i) begin
                cleared <= 1'b0;
            end
        end
    end

    // Per-channel data registers, written flags and output latches.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic host_hit;
            logic eng_hit;
            logic async_load;
            logic sync_ch_load;

            // Host writes reach the data register only while the engine is off.
            assign host_hit = host_wr_i.valid && host_wr_i.chan == 3'(g);
            assign eng_hit  = engine_wr_i.valid && engine_wr_i.chan == 3'(g)
                              && correction_enable_i;

            assign async_load   = correction_enable_i ? eng_hit
                                                      : (host_hit && cs_rise);
            assign sync_ch_load = sync_load && (written[g] || load_all);
            assign load_ch[g]   = (mode == dlu_pkg::DLU_MODE_ASYNC) ? async_load
                                                                     : sync_ch_load;

            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i || (clk_en_i && in_reset)) begin
                    chan_data[g] <= reset_code;
                end else if (clk_en_i) begin
                    if (eng_hit) begin
                        chan_data[g] <= engine_wr_i.data;
                    end else if (host_hit && !correction_enable_i) begin
                        chan_data[g] <= host_wr_i.data;
                    end
                end
            end

            // An asynchronous load takes the write itself, as the data register
            // only picks it up on the same edge.
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i || (clk_en_i && in_reset)) begin
                    latch[g] <= reset_code;
                end else if (clk_en_i && load_ch[g]) begin
                    if (mode == dlu_pkg::DLU_MODE_ASYNC) begin
                        latch[g] <= eng_hit ? engine_wr_i.data : host_wr_i.data;
                    end else begin
                        latch[g] <= chan_data[g];
                    end
                end
            end

            // A write in the same cycle as a load keeps its flag for the next load.
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i || (clk_en_i && in_reset)) begin
                    written[g] <= 1'b0;
                end else if (clk_en_i) begin
                    if (eng_hit || (host_hit && !correction_enable_i)) begin
                        written[g] <= 1'b1;
                    end else if (sync_load) begin
                        written[g] <= 1'b0;
                    end
                end
            end

            // Outputs follow the latch directly; clear only masks them.
            assign out_code_o[g*CODE_W +: CODE_W]  = latch[g];
            assign chan_data_o[g*CODE_W +: CODE_W] = chan_data[g];
            assign out_ground_o[g]  = cleared;
            assign out_buf_hiz_o[g] = cleared;
        end
    endgenerate

    // Input data, gain and zero registers.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || (clk_en_i && in_reset)) begin
            input_data_o <= dlu_pkg::CODE_ZERO;
            gain_o       <= dlu_pkg::GAIN_DEFAULT;
            zero_o       <= dlu_pkg::ZERO_DEFAULT;
        end else if (clk_en_i) begin
            if (host_wr_i.valid) begin
                input_data_o <= host_wr_i.data;
            end
            if (gain_wr_i) begin
                gain_o <= cal_data_i;
            end
            if (zero_wr_i) begin
                zero_o <= cal_data_i;
            end
        end
    end

    // Offset is only loaded in reset; this block has no write path for it.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || (clk_en_i && in_reset)) begin
            offset_on_o  <= strap_i.dual_supply;
            offset_o     <= !strap_i.dual_supply ? dlu_pkg::OFFSET_OFF :
                            (strap_i.code_format_select ? dlu_pkg::OFFSET_TC_G6
                                                        : dlu_pkg::OFFSET_SB_G6);
        end
    end

    // Registered copy of the strapped mode for the status port.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            async_mode_o <= 1'b0;
        end else if (clk_en_i) begin
            async_mode_o <= (mode == dlu_pkg::DLU_MODE_ASYNC);
        end
    end

endmodule : dlu_ctrl

// file: hw/dlu_pkg.sv
/*
 * Package for the converter update and reset control block: widths, reset codes,
 * update modes and the carrier structs shared by the design.
 * Assumes a single 100 MHz clock domain and synchronous, active-high reset.
 */
package dlu_pkg;

    localparam int          NUM_CH        = 8;
    localparam int          CODE_W        = 12;
    localparam int          CH_IDX_W      = 3;
    localparam logic [11:0] CODE_ZERO     = 12'h000;
    localparam logic [11:0] CODE_MID      = 12'h800;
    localparam logic [11:0] OFFSET_SB_G6  = 12'h99a;
    localparam logic [11:0] OFFSET_TC_G6  = 12'h19a;
    localparam logic [11:0] OFFSET_OFF    = 12'h000;
    localparam logic [11:0] GAIN_DEFAULT  = 12'hfff;
    localparam logic [11:0] ZERO_DEFAULT  = 12'h000;

    typedef enum logic {
        DLU_MODE_SYNC,
        DLU_MODE_ASYNC
    } dlu_mode_t;

    typedef enum logic [1:0] {
        DLU_ST_POWERUP,
        DLU_ST_RESET,
        DLU_ST_RUN
    } dlu_state_t;

    // One channel write taken from the serial port or the correction engine.
    typedef struct packed {
        logic                valid;
        logic [2:0]          chan;
        logic [11:0]         data;
    } dlu_wr_t;

    // Pin-level strap settings sampled by the block.
    typedef struct packed {
        logic reset_level_select;
        logic code_format_select;
        logic dual_supply;
    } dlu_strap_t;

endpackage : dlu_pkg

// file: verif/dlu_ctrl_sva.sv
/* Checker for dlu_ctrl: clear, reset loading, serial shutdown and update modes.
   Assumes one clock, synchronous active-high reset and clk_en_i held high. */
`timescale 1ns/1ps
module dlu_ctrl_sva #(
    parameter int NUM_CH = 8,
    parameter int CODE_W = 12
) (
    input wire logic                     ref_clk_i,
    input wire logic                     sys_rst_i,
    input wire logic                     output_clear_n_i,
    input wire logic                     load_latch_n_i,
    input wire logic                     hw_reset_n_i,
    input wire dlu_pkg::dlu_strap_t      strap_i,
    input wire logic                     correction_enable_i,
    input wire logic                     correction_busy_i,
    input wire dlu_pkg::dlu_wr_t         host_wr_i,
    input wire dlu_pkg::dlu_wr_t         engine_wr_i,
    input wire logic                     cs_n_o,
    input wire logic                     sdo_oe_n_o,
    input wire logic                     serial_enable_o,
    input wire logic                     async_mode_o,
    input wire logic                     latch_load_cmd_o,
    input wire logic [NUM_CH-1:0]        out_ground_o,
    input wire logic [NUM_CH-1:0]        out_buf_hiz_o,
    input wire logic [NUM_CH*CODE_W-1:0] out_code_o,
    input wire logic [NUM_CH*CODE_W-1:0] chan_data_o,
    input wire logic [CODE_W-1:0]        input_data_o,
    input wire logic [CODE_W-1:0]        offset_o,
    input wire logic                     offset_on_o,
    input wire logic [CODE_W-1:0]        gain_o,
    input wire logic [CODE_W-1:0]        zero_o
);
    logic [CODE_W-1:0] rst_code;
    logic [CODE_W-1:0] rst_offset;
    dlu_pkg::dlu_wr_t  host_q;
    dlu_pkg::dlu_wr_t  eng_q;

    assign rst_code = (strap_i.reset_level_select == strap_i.code_format_select) ?
                      dlu_pkg::CODE_ZERO : dlu_pkg::CODE_MID;
    assign rst_offset = !strap_i.dual_supply ? dlu_pkg::OFFSET_OFF :
        (strap_i.code_format_select ? dlu_pkg::OFFSET_TC_G6 : dlu_pkg::OFFSET_SB_G6);

    // The last write of each source is kept so a later cycle can find its channel.
    always_ff @(posedge ref_clk_i) begin
        if (host_wr_i.valid) begin
            host_q <= host_wr_i;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (engine_wr_i.valid) begin
            eng_q <= engine_wr_i;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_clear_ground; !output_clear_n_i |=> &out_ground_o && &out_buf_hiz_o; endproperty
    a_clear_ground: assert property (p_clear_ground) else $error("Clear not applied.");
    property p_clear_hold;
        !output_clear_n_i && hw_reset_n_i && !async_mode_o |=> $stable(out_code_o);
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("Latch moved in clear.");
    property p_clear_release; output_clear_n_i && !load_latch_n_i |=> out_ground_o == '0; endproperty
    a_clear_release: assert property (p_clear_release) else $error("Clear kept.");
    property p_hw_serial; !hw_reset_n_i |=> !serial_enable_o && sdo_oe_n_o && cs_n_o; endproperty
    a_hw_serial: assert property (p_hw_serial) else $error("Serial live in reset.");
    property p_hw_codes;
        !hw_reset_n_i |=> out_code_o == {NUM_CH{rst_code}} && chan_data_o == {NUM_CH{rst_code}};
    endproperty
    a_hw_codes: assert property (p_hw_codes) else $error("Bad reset code.");
    property p_hw_regs;
        !hw_reset_n_i |=> input_data_o == '0 && gain_o == dlu_pkg::GAIN_DEFAULT
            && zero_o == dlu_pkg::ZERO_DEFAULT && offset_o == rst_offset
            && offset_on_o == strap_i.dual_supply;
    endproperty
    a_hw_regs: assert property (p_hw_regs) else $error("Bad reset register.");
    property p_async_no_cmd; async_mode_o |-> !latch_load_cmd_o; endproperty
    a_async_no_cmd: assert property (p_async_no_cmd) else $error("Load pending.");
    property p_cmd_once; latch_load_cmd_o && !correction_busy_i |=> !latch_load_cmd_o; endproperty
    a_cmd_once: assert property (p_cmd_once) else $error("Load flag stuck.");
    property p_busy_wait; !async_mode_o && correction_busy_i |=> $stable(out_code_o); endproperty
    a_busy_wait: assert property (p_busy_wait) else $error("Load during busy.");
    property p_direct;
        async_mode_o && !correction_enable_i && host_wr_i.valid && hw_reset_n_i
            |-> ##[1:3] out_code_o[host_q.chan*CODE_W +: CODE_W] == host_q.data;
    endproperty
    a_direct: assert property (p_direct) else $error("Direct update missing.");
    property p_engine;
        async_mode_o && correction_enable_i && engine_wr_i.valid
            |-> ##[1:2] out_code_o[eng_q.chan*CODE_W +: CODE_W] == eng_q.data;
    endproperty
    a_engine: assert property (p_engine) else $error("Engine update missing.");

    c_cmd: cover property (latch_load_cmd_o);
    c_direct: cover property (async_mode_o && host_wr_i.valid);
    c_release: cover property (&out_ground_o ##1 out_ground_o == '0);
endmodule : dlu_ctrl_sva

bind dlu_ctrl dlu_ctrl_sva #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) u_dlu_ctrl_sva (.*);

// file: verif/dlu_host_model.sv
/* Host processor model: strobe level at power-up, hardware reset, chip select
   frames and completed channel writes. Assumes tasks start at a falling edge. */
`timescale 1ns/1ps
module dlu_host_model #(
    parameter int LOAD_GAP = 3
) (
    input  wire logic       ref_clk_i,
    output dlu_pkg::dlu_wr_t host_wr_o,
    output logic            cs_n_o,
    output logic            sdi_o,
    output logic            load_latch_n_o,
    output logic            hw_reset_n_o
);
    initial begin
        host_wr_o = '0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        load_latch_n_o = 1'b1;
        hw_reset_n_o = 1'b0;
    end

    task power(input logic lvl);
        cs_n_o = 1'b1;
        hw_reset_n_o = 1'b0;
        load_latch_n_o = lvl;
    endtask : power

    task release_reset();
        hw_reset_n_o = 1'b1;
    endtask : release_reset

    task write(input logic [2:0] ch, input logic [11:0] data);
        cs_n_o = 1'b0;
        repeat (4) begin
            @(negedge ref_clk_i);
            sdi_o = ~sdi_o;
        end
        cs_n_o = 1'b1;
        host_wr_o = {1'b1, ch, data};
        @(negedge ref_clk_i);
        host_wr_o.valid = 1'b0;
    endtask : write

    task load();
        repeat (LOAD_GAP) @(negedge ref_clk_i);
        load_latch_n_o = 1'b0;
        @(negedge ref_clk_i);
        load_latch_n_o = 1'b1;
    endtask : load
endmodule : dlu_host_model

// file: verif/test_dac_latch_update_reset_ctrl.sv
/* Self-checking bench for dlu_ctrl: reset loading, clear and both update modes.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
module test_dac_latch_update_reset_ctrl;
    logic                ref_clk_i = 1'b0;
    logic                sys_rst_i = 1'b1;
    logic                clear_n = 1'b1;
    logic                corr_en = 1'b0;
    logic                corr_busy = 1'b0;
    logic                cmd_wr = 1'b0;
    dlu_pkg::dlu_strap_t strap = '0;
    dlu_pkg::dlu_wr_t    eng_wr = '0;
    dlu_pkg::dlu_wr_t    host_wr;
    logic                cs_n, sdi, load_n, hw_n, cs_q, sdo, sdo_oe_n, ser_en;
    logic                async_mode, cmd_pend, offset_on;
    logic [7:0]          ground, hiz;
    logic [95:0]         out_code, chan_data, exp_v;
    logic [11:0]         input_data, offset, gain, zero;
    int                  mismatches = 0;
    int                  cmp_count = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    dlu_host_model u_dlu_host_model (.ref_clk_i(ref_clk_i), .host_wr_o(host_wr), .cs_n_o(cs_n),
        .sdi_o(sdi), .load_latch_n_o(load_n), .hw_reset_n_o(hw_n));

    dlu_ctrl u_dlu_ctrl (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .output_clear_n_i(clear_n), .load_latch_n_i(load_n), .hw_reset_n_i(hw_n),
        .strap_i(strap), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_data_i(1'b1),
        .correction_enable_i(corr_en), .correction_busy_i(corr_busy), .host_wr_i(host_wr),
        .engine_wr_i(eng_wr), .latch_load_cmd_wr_i(cmd_wr), .gain_wr_i(1'b0), .zero_wr_i(1'b0),
        .cal_data_i(12'h000), .cs_n_o(cs_q), .sdi_o(), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
        .serial_enable_o(ser_en), .async_mode_o(async_mode), .latch_load_cmd_o(cmd_pend),
        .out_ground_o(ground), .out_buf_hiz_o(hiz), .out_code_o(out_code),
        .chan_data_o(chan_data), .input_data_o(input_data), .offset_o(offset),
        .offset_on_o(offset_on), .gain_o(gain), .zero_o(zero));

    task summarize();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task chk(input string name, input logic [191:0] got, input logic [191:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task cycles(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : cycles

    task do_reset(input dlu_pkg::dlu_strap_t s, input logic lvl);
        @(negedge ref_clk_i);
        strap = s;
        sys_rst_i = 1'b1;
        u_dlu_host_model.power(lvl);
        cycles(16);
        sys_rst_i = 1'b0;
        cycles(4);
    endtask : do_reset

    task release_hw();
        u_dlu_host_model.release_reset();
        for (int i = 0; i < 10 && ser_en !== 1'b1; i++) @(negedge ref_clk_i);
        if (ser_en !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask : release_hw

    task t_reset_values();
        logic [11:0] c;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2:0], 1'b1);
            c = (i[2] == i[1]) ? dlu_pkg::CODE_ZERO : dlu_pkg::CODE_MID;
            u_dlu_host_model.write(3'h1, 12'habc);
            chk("codes", {out_code, chan_data}, {2{{8{c}}}});
            chk("regs", {input_data, gain, zero}, {12'h000, dlu_pkg::GAIN_DEFAULT, 12'h000});
            chk("offset", {offset_on, offset}, {i[0], !i[0] ? dlu_pkg::OFFSET_OFF :
                (i[1] ? dlu_pkg::OFFSET_TC_G6 : dlu_pkg::OFFSET_SB_G6)});
            chk("serial", {ser_en, sdo_oe_n, cs_q}, 3'b011);
            release_hw();
            cycles(4);
            chk("held", out_code, {8{c}});
        end
    endtask : t_reset_values

    task t_sync();
        chk("sync", async_mode, 1'b0);
        u_dlu_host_model.write(3'h2, 12'h5a5);
        cycles(6);
        exp_v = '0;
        chk("idle", out_code, exp_v);
        u_dlu_host_model.load();
        cycles(3);
        exp_v[24 +: 12] = 12'h5a5;
        chk("strobe", out_code, exp_v);
        u_dlu_host_model.write(3'h3, 12'h3c3);
        cycles(3);
        cmd_wr = 1'b1;
        cycles(1);
        cmd_wr = 1'b0;
        cycles(3);
        exp_v[36 +: 12] = 12'h3c3;
        chk("cmd", {cmd_pend, out_code}, {1'b0, exp_v});
        corr_en = 1'b1;
        corr_busy = 1'b1;
        eng_wr = {1'b1, 3'h6, 12'h777};
        cycles(1);
        eng_wr.valid = 1'b0;
        u_dlu_host_model.load();
        cycles(4);
        chk("busy", out_code, exp_v);
        corr_busy = 1'b0;
        cycles(3);
        exp_v[72 +: 12] = 12'h777;
        chk("engine_sync", out_code, exp_v);
        corr_en = 1'b0;
    endtask : t_sync

    task t_clear();
        clear_n = 1'b0;
        cycles(2);
        chk("cleared", {ground, hiz}, 16'hffff);
        u_dlu_host_model.write(3'h4, 12'h444);
        u_dlu_host_model.load();
        cycles(2);
        chk("in_clear", out_code, exp_v);
        clear_n = 1'b1;
        cycles(4);
        chk("still", ground, 8'hff);
        u_dlu_host_model.load();
        cycles(3);
        exp_v[48 +: 12] = 12'h444;
        chk("restored", {ground, out_code}, {8'h00, exp_v});
    endtask : t_clear

    task t_async();
        do_reset(3'b001, 1'b0);
        release_hw();
        chk("async", async_mode, 1'b1);
        u_dlu_host_model.write(3'h1, 12'h111);
        cycles(2);
        exp_v = '0;
        exp_v[12 +: 12] = 12'h111;
        chk("direct", out_code, exp_v);
        cmd_wr = 1'b1;
        cycles(1);
        cmd_wr = 1'b0;
        cycles(2);
        chk("cmd_off", {cmd_pend, out_code}, {1'b0, exp_v});
        corr_en = 1'b1;
        eng_wr = {1'b1, 3'h5, 12'h555};
        cycles(1);
        eng_wr.valid = 1'b0;
        cycles(1);
        exp_v[60 +: 12] = 12'h555;
        chk("engine", out_code, exp_v);
        clear_n = 1'b0;
        cycles(2);
        chk("clr", ground, 8'hff);
        clear_n = 1'b1;
        cycles(2);
        chk("tied", {ground, out_code}, {8'h00, exp_v});
    endtask : t_async

    initial begin
        t_reset_values();
        t_sync();
        t_clear();
        t_async();
        summarize();
    end
endmodule : test_dac_latch_update_reset_ctrl
